// File: rtl/sipr_defines.vh
`ifndef SIPR_DEFINES_VH
`define SIPR_DEFINES_VH
// register byte addresses (index times four)
`define SIPR_IDX_STATUS_B 8'h1C
`define SIPR_IDX_INPUT_REF 8'h1D
`define SIPR_IDX_POWERDOWN 8'h1E
`define SIPR_ADDR_STATUS_B 10'h070
`define SIPR_ADDR_INPUT_REF 10'h074
`define SIPR_ADDR_POWERDOWN 10'h078
`define SIPR_ADDR_W 10
// reset values
`define SIPR_RST_STATUS_B 8'h28
`define SIPR_RST_INPUT_REF 8'h06
`define SIPR_RST_POWERDOWN 8'h00
// writable bit masks
`define SIPR_MASK_STATUS_B 8'hF8
`define SIPR_MASK_INPUT_REF 8'hBF
`define SIPR_MASK_POWERDOWN 8'h7F
// field positions
`define SIPR_SEL_HI 7
`define SIPR_SEL_LO 4
`define SIPR_POL_BIT 3
`define SIPR_BYP_BIT 7
`define SIPR_GND_SEC_BIT 5
`define SIPR_GND_PRI_BIT 4
`define SIPR_DIFF_SEC_BIT 3
`define SIPR_DIFF_PRI_BIT 2
`define SIPR_AC_SEC_BIT 1
`define SIPR_AC_PRI_BIT 0
`define SIPR_CMOS_BIT 6
`define SIPR_CH7_BIT 5
`define SIPR_CH4_BIT 2
`define SIPR_CH23_BIT 1
`define SIPR_CH01_BIT 0
// status selector codes
`define SIPR_SEL_PRI_LOSS 4'h0
`define SIPR_SEL_SEC_LOSS 4'h1
`define SIPR_SEL_LOCK_LOSS 4'h2
`define SIPR_SEL_R_DIV 4'h3
`define SIPR_SEL_N_DIV 4'h4
`define SIPR_SEL_VCO_CAL 4'h8
`define SIPR_SEL_INTERRUPT_SUMMARY 4'hA
`define SIPR_SEL_M_DIV 4'hB
`define SIPR_SEL_EEPROM 4'hD
`define SIPR_SEL_AUTO_SW 4'hE
// axi responses
`define SIPR_RESP_OKAY 2'h0
`define SIPR_RESP_SLVERR 2'h2
`endif

// File: rtl/sipr_status_mux.v
`timescale 1ns/1ns
`include "sipr_defines.vh"
module sipr_status_mux (
  input wire [3:0] i_select,
  input wire i_polarity,
  input wire [9:0] i_events,
  output reg o_level
);
  // i_events: {auto_sw,eeprom,m_div,interrupt_summary,vco_cal,n_div,r_div,lock_loss,sec_loss,pri_loss}
  reg raw;
  always @* begin
    case (i_select)
      `SIPR_SEL_PRI_LOSS: raw = i_events[0];
      `SIPR_SEL_SEC_LOSS: raw = i_events[1];
      `SIPR_SEL_LOCK_LOSS: raw = i_events[2];
      `SIPR_SEL_R_DIV: raw = i_events[3];
      `SIPR_SEL_N_DIV: raw = i_events[4];
      `SIPR_SEL_VCO_CAL: raw = i_events[5];
      `SIPR_SEL_INTERRUPT_SUMMARY: raw = i_events[6];
      `SIPR_SEL_M_DIV: raw = i_events[7];
      `SIPR_SEL_EEPROM: raw = i_events[8];
      `SIPR_SEL_AUTO_SW: raw = i_events[9];
      default: raw = 1'b0;
    endcase
    // reserved codes show inactive at the chosen polarity
    o_level = i_polarity ? raw : ~raw;
  end
endmodule

// File: rtl/sipr_detect_gate.v
`timescale 1ns/1ns
module sipr_detect_gate (
  input wire i_bypass,
  input wire i_pri_loss,
  input wire i_sec_loss,
  output wire o_pri_valid,
  output wire o_sec_valid
);
  // only the pll control path sees the bypass; status keeps raw loss
  assign o_pri_valid = i_bypass | ~i_pri_loss;
  assign o_sec_valid = i_bypass | ~i_sec_loss;
endmodule

// File: rtl/sipr_regs.v
`timescale 1ns/1ns
`include "sipr_defines.vh"
// What this block does
// - selector codes 10,11,13,14 pick upper events
// - selector codes 0-4,8 pick lower events
// - selector field bits 7:4, reset code 2
// - polarity bit 3 high is active high
// - bypass makes pll treat inputs valid
// - bypass leaves status and interrupts raw
// - bits 5/4 select 50 ohm ground termination
// - bits 3/2 select 100 ohm differential termination
// - bits 1/0 enable ac coupling bias
// - bits 5..2 power down channels 7..4
// - bits 1/0 power down channel pairs
// - bit 6 is cmos channel powerdown
module sipr_regs (
  input wire i_core_clk,
  input wire i_rst_b,
  input wire i_clk_en,
  input wire [9:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [9:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire i_pri_loss,
  input wire i_sec_loss,
  input wire i_lock_loss,
  input wire i_r_div_half,
  input wire i_n_div_half,
  input wire i_vco_cal,
  input wire i_interrupt_summary,
  input wire i_m_div_half,
  input wire i_eeprom_active,
  input wire i_auto_switch,
  output reg o_status_pin_b,
  output reg o_pri_valid,
  output reg o_sec_valid,
  output reg o_gnd_term_secondary,
  output reg o_gnd_term_primary,
  output reg o_diff_term_secondary,
  output reg o_diff_term_primary,
  output reg o_ac_bias_secondary,
  output reg o_ac_bias_primary,
  output reg o_cmos_channel_off,
  output reg [3:0] o_chan_four_to_seven_off,
  output reg o_chan_pair_two_three_off,
  output reg o_chan_pair_zero_one_off
);
  reg [7:0] status_b_control;
  reg [7:0] input_ref_options;
  reg [7:0] channel_powerdown;
  reg [9:0] aw_addr;
  reg aw_held;
  reg [7:0] w_data;
  reg w_lane0;
  reg w_held;
  wire next_status_level;
  wire pri_valid;
  wire sec_valid;
  wire do_write;

  function [1:0] addr_hit;
    input [9:0] addr;
    begin
      addr_hit = 2'h0;
      if (addr == `SIPR_ADDR_STATUS_B) addr_hit = 2'h1;
      if (addr == `SIPR_ADDR_INPUT_REF) addr_hit = 2'h2;
      if (addr == `SIPR_ADDR_POWERDOWN) addr_hit = 2'h3;
    end
  endfunction

  sipr_status_mux u_mux (
    .i_select(status_b_control[`SIPR_SEL_HI:`SIPR_SEL_LO]),
    .i_polarity(status_b_control[`SIPR_POL_BIT]),
    .i_events({i_auto_switch, i_eeprom_active, i_m_div_half, i_interrupt_summary,
      i_vco_cal, i_n_div_half, i_r_div_half, i_lock_loss, i_sec_loss, i_pri_loss}),
    .o_level(next_status_level)
  );

  sipr_detect_gate u_gate (
    .i_bypass(input_ref_options[`SIPR_BYP_BIT]),
    .i_pri_loss(i_pri_loss),
    .i_sec_loss(i_sec_loss),
    .o_pri_valid(pri_valid),
    .o_sec_valid(sec_valid)
  );

  assign do_write = aw_held & w_held & ~s_axi_bvalid;

  // address and data are latched independently, so either may arrive first
  always @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      aw_addr <= {`SIPR_ADDR_W{1'b0}};
      aw_held <= 1'b0;
      w_data <= 8'h00;
      w_lane0 <= 1'b0;
      w_held <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `SIPR_RESP_OKAY;
      status_b_control <= `SIPR_RST_STATUS_B;
      input_ref_options <= `SIPR_RST_INPUT_REF;
      channel_powerdown <= `SIPR_RST_POWERDOWN;
    end else if (i_clk_en) begin
      // no new address or data is taken while a write answer is pending
      s_axi_awready <= ~aw_held & ~s_axi_awready & ~s_axi_bvalid;
      s_axi_wready <= ~w_held & ~s_axi_wready & ~s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr <= s_axi_awaddr;
        aw_held <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data <= s_axi_wdata[7:0];
        w_lane0 <= s_axi_wstrb[0];
        w_held <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (addr_hit(aw_addr) == 2'h0) ? `SIPR_RESP_SLVERR : `SIPR_RESP_OKAY;
        if (w_lane0) begin
          // masks keep reserved bits at zero
          case (addr_hit(aw_addr))
            2'h1: status_b_control <= w_data & `SIPR_MASK_STATUS_B;
            2'h2: input_ref_options <= w_data & `SIPR_MASK_INPUT_REF;
            2'h3: channel_powerdown <= w_data & `SIPR_MASK_POWERDOWN;
            default: ;
          endcase
        end
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `SIPR_RESP_OKAY;
    end else if (i_clk_en) begin
      s_axi_arready <= ~s_axi_rvalid & ~s_axi_arready;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `SIPR_RESP_OKAY;
        case (addr_hit(s_axi_araddr))
          2'h1: s_axi_rdata <= {24'h000000, status_b_control};
          2'h2: s_axi_rdata <= {24'h000000, input_ref_options};
          2'h3: s_axi_rdata <= {24'h000000, channel_powerdown};
          default: begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `SIPR_RESP_SLVERR;
          end
        endcase
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // status pin is fed by raw loss flags, never by the bypassed valids
  always @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      o_status_pin_b <= 1'b0;
      o_pri_valid <= 1'b0;
      o_sec_valid <= 1'b0;
      o_gnd_term_secondary <= 1'b0;
      o_gnd_term_primary <= 1'b0;
      o_diff_term_secondary <= 1'b0;
      o_diff_term_primary <= 1'b0;
      o_ac_bias_secondary <= 1'b0;
      o_ac_bias_primary <= 1'b0;
      o_cmos_channel_off <= 1'b0;
      o_chan_four_to_seven_off <= 4'h0;
      o_chan_pair_two_three_off <= 1'b0;
      o_chan_pair_zero_one_off <= 1'b0;
    end else if (i_clk_en) begin
      o_status_pin_b <= next_status_level;
      o_pri_valid <= pri_valid;
      o_sec_valid <= sec_valid;
      o_gnd_term_secondary <= input_ref_options[`SIPR_GND_SEC_BIT];
      o_gnd_term_primary <= input_ref_options[`SIPR_GND_PRI_BIT];
      o_diff_term_secondary <= input_ref_options[`SIPR_DIFF_SEC_BIT];
      o_diff_term_primary <= input_ref_options[`SIPR_DIFF_PRI_BIT];
      o_ac_bias_secondary <= input_ref_options[`SIPR_AC_SEC_BIT];
      o_ac_bias_primary <= input_ref_options[`SIPR_AC_PRI_BIT];
      o_cmos_channel_off <= channel_powerdown[`SIPR_CMOS_BIT];
      // index 3 is channel 7 down to index 0 channel 4
      o_chan_four_to_seven_off <= channel_powerdown[`SIPR_CH7_BIT:`SIPR_CH4_BIT];
      o_chan_pair_two_three_off <= channel_powerdown[`SIPR_CH23_BIT];
      o_chan_pair_zero_one_off <= channel_powerdown[`SIPR_CH01_BIT];
    end
  end
endmodule

// File: test/sipr_regs_properties.sv
`timescale 1ns/1ns
module sipr_regs_properties (
  input wire i_core_clk,
  input wire i_rst_b,
  input wire i_clk_en,
  input wire s_axi_awready,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire [1:0] s_axi_rresp,
  input wire [31:0] s_axi_rdata,
  input wire i_pri_loss,
  input wire i_sec_loss,
  input wire o_pri_valid,
  input wire o_sec_valid
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_b);
  property p_pri_ok; i_rst_b && i_clk_en && !i_pri_loss |=> o_pri_valid; endproperty
  a_pri_ok: assert property (p_pri_ok) else $error("primary valid low");
  property p_sec_ok; i_rst_b && i_clk_en && !i_sec_loss |=> o_sec_valid; endproperty
  a_sec_ok: assert property (p_sec_ok) else $error("secondary valid low");
  property p_b_one; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
  a_b_one: assert property (p_b_one) else $error("write response repeated");
  property p_r_one; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
  a_r_one: assert property (p_r_one) else $error("read response repeated");
  property p_r_upper; s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0; endproperty
  a_r_upper: assert property (p_r_upper) else $error("upper read bits set");
  property p_r_err; s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0; endproperty
  a_r_err: assert property (p_r_err) else $error("error read not zero");
  property p_ar_r; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_ar_r: assert property (p_ar_r) else $error("read answer late");
  property p_b_block; s_axi_bvalid |-> !s_axi_awready; endproperty
  a_b_block: assert property (p_b_block) else $error("address taken during response");
  c_wr: cover property (s_axi_bvalid && s_axi_bready);
  c_rd: cover property (s_axi_rvalid && s_axi_rready);
  c_err: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
endmodule

// File: test/sipr_board_model.sv
`timescale 1ns/1ns
module sipr_board_model (
  input wire i_core_clk,
  input wire [9:0] i_pattern,
  output logic [9:0] o_events
);
  // synchronous event sources; driver format fields live elsewhere
  always @(posedge i_core_clk) o_events <= i_pattern;
endmodule

// File: test/test_sipr_regs.sv
`timescale 1ns/1ns
`include "sipr_defines.vh"
module test_sipr_regs;
  logic i_core_clk = 0, i_rst_b = 0, i_clk_en = 1;
  logic [9:0] s_axi_awaddr = 0, s_axi_araddr = 0, pat = 0;
  logic [31:0] s_axi_wdata = 0, rdv;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  logic [1:0] rsp;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [9:0] ev;
  wire i_pri_loss, i_sec_loss, i_lock_loss, i_r_div_half, i_n_div_half, i_vco_cal;
  wire i_interrupt_summary, i_m_div_half, i_eeprom_active, i_auto_switch;
  wire o_status_pin_b, o_pri_valid, o_sec_valid, o_gnd_term_secondary, o_gnd_term_primary;
  wire o_diff_term_secondary, o_diff_term_primary, o_ac_bias_secondary, o_ac_bias_primary;
  wire o_cmos_channel_off, o_chan_pair_two_three_off, o_chan_pair_zero_one_off;
  wire [3:0] o_chan_four_to_seven_off;
  wire [5:0] refo = {o_gnd_term_secondary, o_gnd_term_primary, o_diff_term_secondary,
    o_diff_term_primary, o_ac_bias_secondary, o_ac_bias_primary};
  wire [6:0] pdo = {o_cmos_channel_off, o_chan_four_to_seven_off, o_chan_pair_two_three_off,
    o_chan_pair_zero_one_off};
  int n_mismatch = 0, cmp_count = 0;
  // event index per selector code, -1 where the code is reserved
  int evmap [16] = '{0, 1, 2, 3, 4, -1, -1, -1, 5, -1, 6, 7, -1, 8, 9, -1};
  assign {i_auto_switch, i_eeprom_active, i_m_div_half, i_interrupt_summary, i_vco_cal,
    i_n_div_half, i_r_div_half, i_lock_loss, i_sec_loss, i_pri_loss} = ev;
  sipr_regs u_sipr_regs (.*);
  sipr_board_model u_sipr_board_model (.i_core_clk(i_core_clk), .i_pattern(pat), .o_events(ev));
  initial forever #20 i_core_clk = ~i_core_clk;
  task cmp(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task complete_run;
    $display("mismatches %0d compares %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task wchk(input logic [9:0] a, input logic [7:0] d, input logic [1:0] er);
    logic tk_a, tk_w, done;
    done = 0;
    @(posedge i_core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    // sample settled values mid-cycle; they are what the next edge sees
    while (!done) begin
      @(negedge i_core_clk);
      tk_a = s_axi_awvalid && s_axi_awready;
      tk_w = s_axi_wvalid && s_axi_wready;
      done = s_axi_bvalid;
      if (done) rsp = s_axi_bresp;
      @(posedge i_core_clk);
      if (tk_a) s_axi_awvalid <= 0;
      if (tk_w) s_axi_wvalid <= 0;
    end
    s_axi_bready <= 0;
    cmp(rsp, er);
  endtask
  task rchk(input logic [9:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic tk, done;
    done = 0;
    @(posedge i_core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    while (!done) begin
      @(negedge i_core_clk);
      tk = s_axi_arvalid && s_axi_arready;
      done = s_axi_rvalid;
      if (done) begin
        rdv = s_axi_rdata;
        rsp = s_axi_rresp;
      end
      @(posedge i_core_clk);
      if (tk) s_axi_arvalid <= 0;
    end
    s_axi_rready <= 0;
    cmp(rdv, ed);
    cmp(rsp, er);
  endtask
  task t_reset;
    rchk(`SIPR_ADDR_STATUS_B, 32'h28, `SIPR_RESP_OKAY);
    rchk(`SIPR_ADDR_INPUT_REF, 32'h06, `SIPR_RESP_OKAY);
    rchk(`SIPR_ADDR_POWERDOWN, 32'h00, `SIPR_RESP_OKAY);
    cmp(refo, 6'h06);
    cmp(pdo, 7'h00);
    $display("reset values done");
  endtask
  task t_input_ref;
    pat <= 10'h003;
    wchk(`SIPR_ADDR_INPUT_REF, 8'hFF, `SIPR_RESP_OKAY);
    wchk(`SIPR_ADDR_STATUS_B, 8'h08, `SIPR_RESP_OKAY);
    rchk(`SIPR_ADDR_INPUT_REF, 32'hBF, `SIPR_RESP_OKAY);
    repeat (4) @(posedge i_core_clk);
    cmp(refo, 6'h3F);
    cmp({o_pri_valid, o_sec_valid}, 2'b11);
    cmp(o_status_pin_b, 1'b1);
    wchk(`SIPR_ADDR_INPUT_REF, 8'h00, `SIPR_RESP_OKAY);
    repeat (4) @(posedge i_core_clk);
    cmp(refo, 6'h00);
    cmp({o_pri_valid, o_sec_valid}, 2'b00);
    $display("input options done");
  endtask
  task t_powerdown;
    logic [7:0] v [3];
    v = '{8'hFF, 8'h55, 8'h2A};
    foreach (v[i]) begin
      wchk(`SIPR_ADDR_POWERDOWN, v[i], `SIPR_RESP_OKAY);
      rchk(`SIPR_ADDR_POWERDOWN, v[i] & 8'h7F, `SIPR_RESP_OKAY);
      repeat (4) @(posedge i_core_clk);
      cmp(pdo, v[i][6:0]);
    end
    $display("powerdown done");
  endtask
  task t_status;
    int ix;
    logic raw;
    logic exp;
    for (int c = 0; c < 32; c++) begin
      ix = evmap[c[4:1]];
      wchk(`SIPR_ADDR_STATUS_B, {c[4:0], 3'h0}, `SIPR_RESP_OKAY);
      rchk(`SIPR_ADDR_STATUS_B, {c[4:0], 3'h0}, `SIPR_RESP_OKAY);
      for (int k = 0; k < 2; k++) begin
        // one-hot then its inverse, so a wrong pick shows either way
        if (ix < 0) pat <= {10{k[0]}};
        else pat <= k ? ~(10'h1 << ix) : (10'h1 << ix);
        raw = (ix >= 0) && (k == 0);
        exp = ~(raw ^ c[0]);
        repeat (4) @(posedge i_core_clk);
        cmp(o_status_pin_b, exp);
      end
    end
    $display("status select done");
  endtask
  task t_freeze;
    wchk(`SIPR_ADDR_STATUS_B, 8'h28, `SIPR_RESP_OKAY);
    pat <= 10'h000;
    repeat (4) @(posedge i_core_clk);
    cmp(o_status_pin_b, 1'b0);
    i_clk_en <= 0;
    pat <= 10'h004;
    repeat (4) @(posedge i_core_clk);
    cmp(o_status_pin_b, 1'b0);
    i_clk_en <= 1;
    repeat (4) @(posedge i_core_clk);
    cmp(o_status_pin_b, 1'b1);
    pat <= 10'h000;
    $display("clock enable done");
  endtask
  task t_unmapped;
    wchk(10'h07C, 8'hFF, `SIPR_RESP_SLVERR);
    rchk(10'h07C, 32'h0, `SIPR_RESP_SLVERR);
    $display("unmapped done");
  endtask
  initial begin
    repeat (12) @(posedge i_core_clk);
    i_rst_b <= 1;
    t_reset;
    t_input_ref;
    t_powerdown;
    t_status;
    t_freeze;
    t_unmapped;
    complete_run;
  end
  initial begin
    repeat (6000) @(posedge i_core_clk);
    n_mismatch++;
    complete_run;
  end
endmodule
bind sipr_regs sipr_regs_properties u_sipr_regs_properties (.*);
